//--- cms_asserts.sv
// port-level checker for clock management and sleep control
// assumes a bind by name to cms_top and one clock domain
`timescale 1ns/10ps
module cms_asserts (
	input wire logic CLK_SYS_I,
	input wire logic RESET_I,
	input wire logic IO_WRITE_I,
	input wire logic IO_AUX_I,
	input wire logic [3:0] IO_ADDR_I,
	input wire logic [3:0] IO_DATA_I,
	input wire cms_pkg::cms_osc_s OSC_TICK_I,
	input wire logic SLEEP_REQ_I,
	input wire logic IRQ_PENDING_I,
	input wire logic IRQ_ACTIVE_I,
	input wire logic WATCHDOG_LOCK_SIGNAL_I,
	input wire logic CORE_CLK_EN_O,
	input wire logic PERIPH_CLK_EN_O,
	input wire logic INT_ENABLE_SET_O,
	input wire logic SLEEPING_O,
	input wire logic WAKE_O,
	input wire logic BROWNOUT_ENABLE_O,
	input wire logic BROWNOUT_LOW_SEL_O,
	input wire logic SUPERVISOR_RESET_O,
	input wire logic SYNC_BUSY_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);
	logic wr_cm;
	logic wr_sc;
	logic keep_r;
	logic bot_r;
	assign wr_cm = IO_WRITE_I && IO_ADDR_I == cms_pkg::CMS_IO_ADDR && IO_AUX_I;
	assign wr_sc = IO_WRITE_I && IO_ADDR_I == cms_pkg::CMS_IO_ADDR && !IO_AUX_I;
	// shadows, since the registers cannot be read back
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I)
			keep_r <= 1'b1;
		else if (wr_cm)
			keep_r <= IO_DATA_I[3];
	end
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I)
			bot_r <= 1'b1;
		else if (wr_sc)
			bot_r <= IO_DATA_I[3];
	end
	sequence s_sleep_ok;
		SLEEP_REQ_I && !IRQ_PENDING_I && !IRQ_ACTIVE_I;
	endsequence
	sequence s_irq_asleep;
		SLEEPING_O && (IRQ_PENDING_I || IRQ_ACTIVE_I);
	endsequence
	a_int_en_set: assert property (SLEEP_REQ_I |=> INT_ENABLE_SET_O)
		else $error("no interrupt enable pulse after sleep request");
	a_sleep_enter: assert property (s_sleep_ok |=> SLEEPING_O)
		else $error("sleep not entered");
	a_wake_exit: assert property (s_irq_asleep |=> !SLEEPING_O && WAKE_O)
		else $error("interrupt did not end sleep");
	a_irq_blocks: assert property ((IRQ_PENDING_I || IRQ_ACTIVE_I) && !SLEEPING_O
		|=> !SLEEPING_O)
		else $error("sleep entered with interrupt present");
	a_core_gated: assert property (SLEEPING_O |-> !CORE_CLK_EN_O)
		else $error("core clock runs in sleep");
	a_periph_gated: assert property (SLEEPING_O && !keep_r |-> !PERIPH_CLK_EN_O)
		else $error("peripheral clock runs in sleep with keep off");
	a_cm_sync: assert property (wr_cm |-> ##2 SYNC_BUSY_O)
		else $error("write did not start a sync cycle");
	a_bot_follow: assert property (BROWNOUT_LOW_SEL_O == $past(bot_r))
		else $error("brown-out threshold select wrong");
	a_sup_no_tick: assert property (SUPERVISOR_RESET_O
		|-> !$past(OSC_TICK_I.ext) && !$past(OSC_TICK_I.ext, 2))
		else $error("supervisor reset despite external ticks");
	a_osc_stop: assert property ((SLEEPING_O && !keep_r && WATCHDOG_LOCK_SIGNAL_I)[*2]
		|-> !BROWNOUT_ENABLE_O)
		else $error("brown-out still on in oscillator stop");
endmodule : cms_asserts

//--- cms_pkg.sv
// constants, field layouts and types for clock management and sleep control
// assumes oscillators reach the block as one-cycle tick pulses on CLK_SYS_I
package cms_pkg;

	// i/o port address shared by the primary and the auxiliary register
	localparam logic [3:0] CMS_IO_ADDR = 4'h3;

	// clock management register layout (auxiliary register)
	typedef struct packed {
		logic peripheral_clock_keep_in_sleep;
		logic ccs;
		logic core_speed_select_hi;
		logic core_speed_select_lo;
	} cms_cm_s;

	// system configuration register layout (primary register)
	typedef struct packed {
		logic brownout_threshold_select;
		logic unused;
		logic oscillator_select_hi;
		logic oscillator_select_lo;
	} cms_sc_s;

	localparam cms_cm_s CMS_CM_RESET = 4'hf;
	localparam cms_sc_s CMS_SC_RESET = 4'hb;

	// oscillator select codes
	localparam logic [1:0] CMS_OS_EXT = 2'h3;
	localparam logic [1:0] CMS_OS_RC2 = 2'h1;
	localparam logic [1:0] CMS_OS_XT4 = 2'h2;
	localparam logic [1:0] CMS_OS_XT32 = 2'h0;

	// core speed select codes
	localparam logic [1:0] CMS_CSS_DIV16 = 2'h0;
	localparam logic [1:0] CMS_CSS_DIV8 = 2'h3;
	localparam logic [1:0] CMS_CSS_DIV4 = 2'h2;
	localparam logic [1:0] CMS_CSS_DIV2 = 2'h1;

	// divider terminal counts (divide ratio minus one)
	localparam int CMS_DIV_W = 4;
	localparam logic [3:0] CMS_TC_DIV16 = 4'hf;
	localparam logic [3:0] CMS_TC_DIV8 = 4'h7;
	localparam logic [3:0] CMS_TC_DIV4 = 4'h3;
	localparam logic [3:0] CMS_TC_DIV2 = 4'h1;
	localparam logic [3:0] CMS_TC_SUB = 4'hf;

	// external clock supervisor timing
	localparam int CMS_CLK_MHZ = 125;
	localparam int CMS_EXT_MISS_US = 1000;
	localparam int CMS_EXT_MISS_CYC = CMS_EXT_MISS_US * CMS_CLK_MHZ;
	localparam int CMS_SUP_W = 32;

	// oscillator ticks in, oscillator run enables out
	typedef struct packed {
		logic rc1;
		logic rc2;
		logic xt4;
		logic xt32;
		logic ext;
	} cms_osc_s;

	typedef enum {
		CMS_SYNC_IDLE,
		CMS_SYNC_WAIT_OLD,
		CMS_SYNC_WAIT_NEW
	} cms_sync_e;

	function automatic logic [3:0] cms_div_tc(input logic [1:0] css);
		logic [3:0] tc;
		tc = CMS_TC_DIV8;
		case (css)
			CMS_CSS_DIV16: tc = CMS_TC_DIV16;
			CMS_CSS_DIV8: tc = CMS_TC_DIV8;
			CMS_CSS_DIV4: tc = CMS_TC_DIV4;
			CMS_CSS_DIV2: tc = CMS_TC_DIV2;
			default: tc = CMS_TC_DIV8;
		endcase
		return tc;
	endfunction : cms_div_tc

endpackage : cms_pkg

//--- cms_tick_div.sv
// tick divider: one output pulse for every (tc+1) input ticks
// assumes ticks are single-cycle pulses synchronous to clk_i
`timescale 1ns/10ps
module cms_tick_div #(
	parameter int W = 4
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic tick_i,
	input wire logic restart_i,
	input wire logic [W-1:0] tc_i,
	output logic pulse_o
);

	logic [W-1:0] cnt_r;

	// restart wins so a new ratio begins from a clean count
	always_ff @(posedge clk_i) begin
		if (reset_i || restart_i) begin
			cnt_r <= '0;
		end else if (tick_i) begin
			if (cnt_r >= tc_i) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || restart_i) begin
			pulse_o <= 1'b0;
		end else begin
			pulse_o <= tick_i && (cnt_r >= tc_i);
		end
	end

endmodule : cms_tick_div

//--- cms_top.sv
// clock source selection, core divider, sub-clock, sleep and osc stop
// assumes the core writes registers over the i/o bus, one cycle per OUT,
// and that all oscillator ticks are pulses synchronous to CLK_SYS_I
`timescale 1ns/10ps
module cms_top #(
	parameter int EXT_MISS_CYCLES = cms_pkg::CMS_EXT_MISS_CYC,
	parameter logic WDL_STOP_LEVEL = 1'b1
) (
	input wire logic CLK_SYS_I,
	input wire logic RESET_I,
	input wire logic IO_WRITE_I,
	input wire logic IO_AUX_I,
	input wire logic [3:0] IO_ADDR_I,
	input wire logic [3:0] IO_DATA_I,
	input wire cms_pkg::cms_osc_s OSC_TICK_I,
	input wire logic SLEEP_REQ_I,
	input wire logic IRQ_PENDING_I,
	input wire logic IRQ_ACTIVE_I,
	input wire logic WATCHDOG_LOCK_SIGNAL_I,
	output cms_pkg::cms_osc_s OSC_RUN_O,
	output logic SYS_CLK_EN_O,
	output logic CORE_CLK_EN_O,
	output logic PERIPH_CLK_EN_O,
	output logic PERIPHERAL_SUB_CLOCK_O,
	output logic INT_ENABLE_SET_O,
	output logic SLEEPING_O,
	output logic WAKE_O,
	output logic BROWNOUT_ENABLE_O,
	output logic BROWNOUT_LOW_SEL_O,
	output logic SUPERVISOR_RESET_O,
	output logic SYNC_BUSY_O
);

	cms_pkg::cms_cm_s cm_r;
	cms_pkg::cms_sc_s sc_r;
	logic wr_cm;
	logic wr_sc;

	// settings that currently drive the system clock
	logic act_ccs_r;
	logic [1:0] act_os_r;
	logic [1:0] act_css_r;
	cms_pkg::cms_sync_e sync_r;
	cms_pkg::cms_sync_e sync_nxt;
	logic sync_req_r;
	logic apply;

	logic [1:0] new_css;
	logic old_tick;
	logic new_tick;
	logic alt_tick;
	logic sys_tick;
	logic sub_div_tick;
	logic sub_tick;

	logic sleep_r;
	logic osc_stop;
	logic irq_any;

	logic [cms_pkg::CMS_SUP_W-1:0] miss_cnt_r;
	logic sup_armed;

	// pick one tick stream from core select and oscillator select
	function automatic logic pick_tick(input logic ccs, input logic [1:0] os,
			input cms_pkg::cms_osc_s t);
		logic r;
		r = 1'b0;
		if (ccs) begin
			r = t.rc1;
		end else begin
			case (os)
				cms_pkg::CMS_OS_EXT: r = t.ext;
				cms_pkg::CMS_OS_RC2: r = t.rc2;
				cms_pkg::CMS_OS_XT4: r = t.xt4;
				cms_pkg::CMS_OS_XT32: r = t.xt32;
				default: r = 1'b0;
			endcase
		end
		return r;
	endfunction : pick_tick

	// register writes: primary is system config, auxiliary is clock mgmt
	assign wr_sc = IO_WRITE_I && !IO_AUX_I
		&& (IO_ADDR_I == cms_pkg::CMS_IO_ADDR);
	assign wr_cm = IO_WRITE_I && IO_AUX_I
		&& (IO_ADDR_I == cms_pkg::CMS_IO_ADDR);

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			cm_r <= cms_pkg::CMS_CM_RESET;
		end else if (wr_cm) begin
			cm_r <= IO_DATA_I;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			sc_r <= cms_pkg::CMS_SC_RESET;
		end else if (wr_sc) begin
			sc_r <= {IO_DATA_I[3], 1'b0, IO_DATA_I[1:0]};
		end
	end

	// brown-out threshold select straight from the register
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			BROWNOUT_LOW_SEL_O <= cms_pkg::CMS_SC_RESET.brownout_threshold_select;
		end else begin
			BROWNOUT_LOW_SEL_O <= sc_r.brownout_threshold_select;
		end
	end

	// a pending request survives writes that land mid-cycle; newest values win
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			sync_req_r <= 1'b0;
		end else if (wr_cm || wr_sc) begin
			sync_req_r <= 1'b1;
		end else if (sync_r == cms_pkg::CMS_SYNC_WAIT_OLD) begin
			sync_req_r <= 1'b0;
		end
	end

	assign new_css = {cm_r.core_speed_select_hi, cm_r.core_speed_select_lo};
	assign old_tick = pick_tick(act_ccs_r, act_os_r, OSC_TICK_I);
	assign new_tick = pick_tick(cm_r.ccs,
		{sc_r.oscillator_select_hi, sc_r.oscillator_select_lo},
		OSC_TICK_I);

	// wait for the end of an old output period, then for the new source edge
	always_comb begin
		sync_nxt = sync_r;
		case (sync_r)
			cms_pkg::CMS_SYNC_IDLE: begin
				if (sync_req_r) begin
					sync_nxt = cms_pkg::CMS_SYNC_WAIT_OLD;
				end
			end
			cms_pkg::CMS_SYNC_WAIT_OLD: begin
				if (sys_tick) begin
					sync_nxt = cms_pkg::CMS_SYNC_WAIT_NEW;
				end
			end
			cms_pkg::CMS_SYNC_WAIT_NEW: begin
				if (new_tick) begin
					sync_nxt = cms_pkg::CMS_SYNC_IDLE;
				end
			end
			default: sync_nxt = cms_pkg::CMS_SYNC_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			sync_r <= cms_pkg::CMS_SYNC_IDLE;
		end else begin
			sync_r <= sync_nxt;
		end
	end

	assign apply = (sync_r == cms_pkg::CMS_SYNC_WAIT_NEW) && new_tick;

	// source and ratio change in the same cycle, never apart
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			act_ccs_r <= cms_pkg::CMS_CM_RESET.ccs;
			act_os_r <= {cms_pkg::CMS_SC_RESET.oscillator_select_hi,
				cms_pkg::CMS_SC_RESET.oscillator_select_lo};
			act_css_r <= {cms_pkg::CMS_CM_RESET.core_speed_select_hi,
				cms_pkg::CMS_CM_RESET.core_speed_select_lo};
		end else if (apply) begin
			act_ccs_r <= cm_r.ccs;
			act_os_r <= {sc_r.oscillator_select_hi, sc_r.oscillator_select_lo};
			act_css_r <= new_css;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			SYNC_BUSY_O <= 1'b0;
		end else begin
			SYNC_BUSY_O <= (sync_nxt != cms_pkg::CMS_SYNC_IDLE);
		end
	end

	// system clock divider restarts on the switch so no short first period
	cms_tick_div #(
		.W(cms_pkg::CMS_DIV_W)
	) u_sys_div (
		.clk_i(CLK_SYS_I),
		.reset_i(RESET_I),
		.tick_i(old_tick),
		.restart_i(apply),
		.tc_i(cms_pkg::cms_div_tc(act_css_r)),
		.pulse_o(sys_tick)
	);

	// sub-clock follows the oscillator select only, not the core select
	always_comb begin
		alt_tick = 1'b0;
		case (act_os_r)
			cms_pkg::CMS_OS_EXT: alt_tick = OSC_TICK_I.ext;
			cms_pkg::CMS_OS_RC2: alt_tick = OSC_TICK_I.rc2;
			cms_pkg::CMS_OS_XT4: alt_tick = OSC_TICK_I.xt4;
			cms_pkg::CMS_OS_XT32: alt_tick = OSC_TICK_I.xt32;
			default: alt_tick = 1'b0;
		endcase
	end

	cms_tick_div #(
		.W(cms_pkg::CMS_DIV_W)
	) u_sub_div (
		.clk_i(CLK_SYS_I),
		.reset_i(RESET_I),
		.tick_i(alt_tick),
		.restart_i(apply),
		.tc_i(cms_pkg::CMS_TC_SUB),
		.pulse_o(sub_div_tick)
	);

	assign sub_tick = (act_os_r == cms_pkg::CMS_OS_XT32) ?
		OSC_TICK_I.xt32 : sub_div_tick;

	// sleep entry, hold and exit
	assign irq_any = IRQ_PENDING_I || IRQ_ACTIVE_I;

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			sleep_r <= 1'b0;
		end else if (sleep_r && irq_any) begin
			sleep_r <= 1'b0;
		end else if (SLEEP_REQ_I && !irq_any) begin
			sleep_r <= 1'b1;
		end
	end

	// inter-instruction spacing before sleep is the program's duty
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			INT_ENABLE_SET_O <= 1'b0;
		end else begin
			INT_ENABLE_SET_O <= SLEEP_REQ_I;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			WAKE_O <= 1'b0;
		end else begin
			WAKE_O <= sleep_r && irq_any;
		end
	end

	assign SLEEPING_O = sleep_r;

	// clock enables; core halts in sleep, peripherals per keep bit
	assign SYS_CLK_EN_O = sys_tick;
	assign CORE_CLK_EN_O = sys_tick && !sleep_r;
	assign PERIPH_CLK_EN_O = sys_tick
		&& (!sleep_r || cm_r.peripheral_clock_keep_in_sleep);
	assign PERIPHERAL_SUB_CLOCK_O = sub_tick
		&& (!sleep_r || cm_r.peripheral_clock_keep_in_sleep);

	// watchdog lock polarity is a parameter, it is not pinned down
	assign osc_stop = sleep_r && !cm_r.peripheral_clock_keep_in_sleep
		&& (WATCHDOG_LOCK_SIGNAL_I == WDL_STOP_LEVEL);

	// oscillator run enables; 32 kHz never stops while selected
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			OSC_RUN_O.rc1 <= 1'b1;
			OSC_RUN_O.rc2 <= 1'b0;
			OSC_RUN_O.xt4 <= 1'b0;
			OSC_RUN_O.xt32 <= 1'b0;
			OSC_RUN_O.ext <= 1'b0;
		end else begin
			OSC_RUN_O.rc1 <= act_ccs_r && !osc_stop;
			OSC_RUN_O.rc2 <= (act_os_r == cms_pkg::CMS_OS_RC2)
				&& !osc_stop;
			OSC_RUN_O.xt4 <= (act_os_r == cms_pkg::CMS_OS_XT4)
				&& !osc_stop;
			OSC_RUN_O.ext <= (act_os_r == cms_pkg::CMS_OS_EXT)
				&& !osc_stop;
			OSC_RUN_O.xt32 <= (act_os_r == cms_pkg::CMS_OS_XT32);
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			BROWNOUT_ENABLE_O <= 1'b1;
		end else begin
			BROWNOUT_ENABLE_O <= !osc_stop;
		end
	end

	// external clock supervisor; idle while the external stage is stopped
	// counter restarts after a pulse, so a dead input keeps pulsing
	assign sup_armed = !act_ccs_r && (act_os_r == cms_pkg::CMS_OS_EXT)
		&& !osc_stop;

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I || !sup_armed || OSC_TICK_I.ext) begin
			miss_cnt_r <= '0;
		end else if (miss_cnt_r <= EXT_MISS_CYCLES[cms_pkg::CMS_SUP_W-1:0]) begin
			miss_cnt_r <= miss_cnt_r + 1'b1;
		end else begin
			miss_cnt_r <= '0;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			SUPERVISOR_RESET_O <= 1'b0;
		end else begin
			SUPERVISOR_RESET_O <= sup_armed && !OSC_TICK_I.ext
				&& (miss_cnt_r
				> EXT_MISS_CYCLES[cms_pkg::CMS_SUP_W-1:0]);
		end
	end

endmodule : cms_top

//--- tb_top.sv
// self-checking bench for clock management and sleep control
// assumes cms_top with a short supervisor limit, one clock domain
`timescale 1ns/10ps
bind cms_top cms_asserts i_cms_asserts (.*);
module tb_top;
	localparam int MISS = 50;
	logic CLK_SYS_I = 1'b0;
	logic RESET_I = 1'b1;
	logic IO_WRITE_I = 1'b0;
	logic IO_AUX_I = 1'b0;
	logic [3:0] IO_ADDR_I = 4'h3;
	logic [3:0] IO_DATA_I = 4'h0;
	cms_pkg::cms_osc_s OSC_TICK_I = 5'h00;
	logic SLEEP_REQ_I = 1'b0;
	logic IRQ_PENDING_I = 1'b0;
	logic IRQ_ACTIVE_I = 1'b0;
	logic WATCHDOG_LOCK_SIGNAL_I = 1'b0;
	cms_pkg::cms_osc_s OSC_RUN_O;
	logic SYS_CLK_EN_O;
	logic CORE_CLK_EN_O;
	logic PERIPH_CLK_EN_O;
	logic PERIPHERAL_SUB_CLOCK_O;
	logic INT_ENABLE_SET_O;
	logic SLEEPING_O;
	logic WAKE_O;
	logic BROWNOUT_ENABLE_O;
	logic BROWNOUT_LOW_SEL_O;
	logic SUPERVISOR_RESET_O;
	logic SYNC_BUSY_O;
	int seed = 65782;
	int miscompares = 0;
	int n_checks = 0;
	int nc;
	int np;
	int n;
	logic b;
	logic [4:0] mask = 5'h1f;
	logic rnd_on = 1'b1;
	cms_top #(.EXT_MISS_CYCLES(MISS)) i_cms_top (.*);
	always #4 CLK_SYS_I = ~CLK_SYS_I;
	// random ticks, masked; measurements switch to steady ticks
	always @(posedge CLK_SYS_I) begin
		OSC_TICK_I <= rnd_on ? 5'($random(seed)) & mask : mask;
	end
	function automatic int ediv(input int c);
		return c == 0 ? 16 : c == 3 ? 8 : c == 2 ? 4 : 2;
	endfunction : ediv
	function automatic logic [4:0] osel(input int o);
		return o == 3 ? 5'h01 : o == 2 ? 5'h04 : o == 1 ? 5'h08 : 5'h02;
	endfunction : osel
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic rst;
		RESET_I <= 1'b1;
		repeat (2) @(posedge CLK_SYS_I);
		RESET_I <= 1'b0;
		#1;
		chk(OSC_RUN_O, 8'h10);
		chk(BROWNOUT_LOW_SEL_O, 8'h1);
		@(posedge CLK_SYS_I);
		#1;
		chk(OSC_RUN_O, 8'h11);
	endtask : rst
	task automatic wr(input logic aux, input logic [3:0] d);
		int i;
		@(posedge CLK_SYS_I);
		IO_WRITE_I <= 1'b1;
		IO_AUX_I <= aux;
		IO_DATA_I <= d;
		@(posedge CLK_SYS_I);
		IO_WRITE_I <= 1'b0;
		@(posedge CLK_SYS_I);
		#1;
		chk(SYNC_BUSY_O, 8'h1);
		for (i = 0; i < 200 && SYNC_BUSY_O !== 1'b0; i++) begin
			@(posedge CLK_SYS_I);
			#1;
		end
		chk(SYNC_BUSY_O, 8'h0);
	endtask : wr
	// pulses in a 64-cycle window with every tick present
	task automatic meas(input logic sub, input int div);
		int k;
		k = 0;
		rnd_on = 1'b0;
		repeat (20) @(posedge CLK_SYS_I);
		repeat (64) begin
			@(posedge CLK_SYS_I);
			#1;
			k += sub ? PERIPHERAL_SUB_CLOCK_O : SYS_CLK_EN_O;
		end
		rnd_on = 1'b1;
		chk(8'(k), 8'(64 / div));
	endtask : meas
	task automatic slp(input logic s);
		repeat (3) @(posedge CLK_SYS_I);
		@(posedge CLK_SYS_I);
		SLEEP_REQ_I <= 1'b1;
		@(posedge CLK_SYS_I);
		SLEEP_REQ_I <= 1'b0;
		#1;
		chk(INT_ENABLE_SET_O, 8'h1);
		chk(SLEEPING_O, 8'(s));
	endtask : slp
	task automatic wake;
		@(posedge CLK_SYS_I);
		IRQ_PENDING_I <= 1'b1;
		@(posedge CLK_SYS_I);
		IRQ_PENDING_I <= 1'b0;
		#1;
		chk({SLEEPING_O, WAKE_O}, 8'h1);
	endtask : wake
	task automatic run(output int c, output int p);
		c = 0;
		p = 0;
		repeat (32) begin
			@(posedge CLK_SYS_I);
			#1;
			c += CORE_CLK_EN_O;
			p += PERIPH_CLK_EN_O;
		end
	endtask : run
	initial begin
		#80000;
		miscompares++;
		end_of_test;
	end
	initial begin
		rst();
		meas(0, 8);
		for (int c = 0; c < 4; c++) begin
			wr(1, 4'hc | 4'(c));
			meas(0, ediv(c));
		end
		for (int o = 0; o < 4; o++) begin
			b = 1'($random(seed));
			mask = 5'h1f;
			wr(0, {b, 1'b0, 2'(o)});
			wr(1, 4'h9);
			chk(BROWNOUT_LOW_SEL_O, 8'(b));
			mask = osel(o);
			meas(0, 2);
			chk(OSC_RUN_O.rc1, 8'h0);
			meas(1, o == 0 ? 1 : 16);
		end
		// external source selected and now silent
		mask = 5'h1e;
		n = 0;
		while (SUPERVISOR_RESET_O !== 1'b1 && n < 200) begin
			@(posedge CLK_SYS_I);
			#1;
			n++;
		end
		chk(8'(n > MISS && n < MISS + 6), 8'h1);
		mask = 5'h1f;
		rst();
		slp(1);
		run(nc, np);
		chk(8'(nc), 8'h0);
		chk(8'(np > 0), 8'h1);
		wake();
		IRQ_ACTIVE_I <= 1'b1;
		slp(0);
		IRQ_ACTIVE_I <= 1'b0;
		wr(1, 4'h7);
		for (int w = 0; w < 2; w++) begin
			WATCHDOG_LOCK_SIGNAL_I <= w[0];
			slp(1);
			run(nc, np);
			chk(8'(np), 8'h0);
			chk(BROWNOUT_ENABLE_O, 8'(!w[0]));
			chk(OSC_RUN_O, w[0] ? 8'h00 : 8'h11);
			wake();
		end
		wr(0, 4'h8);
		slp(1);
		run(nc, np);
		chk(OSC_RUN_O, 8'h02);
		wake();
		end_of_test;
	end
endmodule : tb_top
